/* File: pbr_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Vector bit 7 is the leftmost (bit 0) field position on the bus
// Notes: Definitions only
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH

`define PBR_ADDR_W 4
`define PBR_ADDR_STATUS 4'h0
`define PBR_ADDR_CAPS 4'h2
`define PBR_ADDR_SPEED 4'h3
`define PBR_ADDR_NODE 4'h4
`define PBR_ADDR_EVENT 4'h5
`define PBR_ADDR_SELECT 4'h7
`define PBR_ADDR_PAGED_BIT 3

`define PBR_EXT_CODE 3'h7
`define PBR_PORT_COUNT 4'h2
`define PBR_SPEED_CODE 3'h2
`define PBR_DELAY_CODE 4'h0
`define PBR_JITTER_CODE 3'h0

`define PBR_B0_CPS 0
`define PBR_B4_LINK_ACTIVE_CTRL 7
`define PBR_B4_CONT 6
`define PBR_B5_WDOG 7
`define PBR_B5_SHORT_BUS_RESET_REQ 6
`define PBR_B5_LOOP 5
`define PBR_B5_PFAIL 4
`define PBR_B5_TMO 3
`define PBR_B5_PEVT 2
`define PBR_B5_ACCEL 1
`define PBR_B5_MULTI 0

`define PBR_RST_LINK_ACTIVE_CTRL 1'b1
`define PBR_RST_CONT 1'b0
`define PBR_RST_FLAG 1'b0
`define PBR_RST_PAGE 3'h0
`define PBR_RST_PORT 4'h0
`define PBR_PAGE_RSVD_LO 3'h2
`define PBR_PAGE_RSVD_HI 3'h6

`define PBR_CLK_NS 40
`define PBR_SBR_TIME_NS 1300
`define PBR_SBR_CYCLES ((`PBR_SBR_TIME_NS + `PBR_CLK_NS - 1) / `PBR_CLK_NS)

`endif

/* File: pbr_pkg.sv */
// Purpose: Shared types of the PHY base register bank
// Assumes: Constants live in pbr_map.svh
// Notes: Two ports are built in
package pbr_pkg;
	typedef logic [7:0] pbr_byte_t;
	typedef logic [1:0] pbr_ports_t;
	typedef logic [5:0] pbr_cnt_t;
endpackage : pbr_pkg

/* File: pbr_evt_if.sv */
// Purpose: Port status bundle between bank and port event detector
// Assumes: Single clock domain
// Notes: Detector outputs are registered
`timescale 1ns/1ps
interface pbr_evt_if;
	import pbr_pkg::*;
	pbr_ports_t bias;
	pbr_ports_t conn;
	pbr_ports_t dis;
	pbr_ports_t fault;
	pbr_ports_t int_en;
	pbr_ports_t resume;
	logic change;
	logic resume_any;
	modport bank (output bias, conn, dis, fault, int_en, resume,
		input change, resume_any);
	modport det (input bias, conn, dis, fault, int_en, resume,
		output change, resume_any);
endinterface : pbr_evt_if

/* File: pbr_port_evt.sv */
// Purpose: Per-port status change and resume start detection
// Assumes: Status inputs synchronous to sys_clk_i
// Notes: First cycle after reset only primes the history
`timescale 1ns/1ps
module pbr_port_evt (
	input wire logic sys_clk_i, // System clock
	input wire logic rstn_i, // Synchronous reset, active low
	pbr_evt_if.det ev // Port status and event pulses
);
	import pbr_pkg::*;

	typedef struct packed {
		logic primed;
		pbr_ports_t bias;
		pbr_ports_t conn;
		pbr_ports_t dis;
		pbr_ports_t fault;
		pbr_ports_t resume;
		logic change;
		logic resume_any;
	} pbr_evt_st_t;

	pbr_evt_st_t st;
	pbr_evt_st_t next_st;
	pbr_ports_t hit;
	pbr_ports_t rise;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_port
			// Bias is not watched while the port is disabled
			assign hit[g] = ev.int_en[g] & (
				((ev.bias[g] ^ st.bias[g]) & ~ev.dis[g]) |
				(ev.conn[g] ^ st.conn[g]) |
				(ev.dis[g] ^ st.dis[g]) |
				(ev.fault[g] ^ st.fault[g]));
			assign rise[g] = ev.resume[g] & ~st.resume[g];
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.primed = 1'b1;
		next_st.bias = ev.bias;
		next_st.conn = ev.conn;
		next_st.dis = ev.dis;
		next_st.fault = ev.fault;
		next_st.resume = ev.resume;
		next_st.change = st.primed & (|hit);
		next_st.resume_any = st.primed & (|rise);
		if (!rstn_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st <= next_st;
	end

	assign ev.change = st.change;
	assign ev.resume_any = st.resume_any;
endmodule : pbr_port_evt

/* File: pbr_base_regs.sv */
// Purpose: Base register bank (addresses 0-7) of a two-port cable PHY
// Assumes: All inputs synchronous to sys_clk_i, 25 MHz
// Notes: Paged registers live outside; reads answer one cycle later
// Operation
// - Extended code reads constant 111b
// - Port count reads constant two
// - Speed code reads constant S400 (010b)
// - Repeater delay field reads zero
// - Repeater jitter field reads zero
// - Self-ID bit 9 is link control AND LINK_POWER_STATUS_IN
// - Link control set by reset, kept on bus reset
// - Link interface follows only link power status
// - Contender bit goes to self-ID bit 20
// - Power class from pins, to self-ID 21-23
// - Watchdog lets resume start set port event
// - Short bus reset request, cleared by bus reset
// - Loop flag on tree-ID timeout, write-one clears
// - Loop plus watchdog wakes inactive link
// - Power fail flag on falling cable power
// - State timeout sets flag and bus reset
// - Port event on enabled port status change
// - Accelerated arbitration enable, reset clears
// - Multispeed concatenation enable, reset clears
// - Page select chooses decode of 8-15
// - Port select chooses per-port registers
// - Addresses 0-7 page independent, 8-15 paged
`timescale 1ns/1ps
`include "pbr_map.svh"
module pbr_base_regs (
	input wire logic sys_clk_i, // System clock, 25 MHz
	input wire logic rstn_i, // Hardware reset, sync, active low
	input wire logic [3:0] reg_addr_i, // Register address
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	input wire pbr_pkg::pbr_byte_t reg_wdata_i, // Write data
	output logic [7:0] reg_rdata_o, // Read data
	output logic reg_rvalid_o, // Read data valid pulse
	input wire pbr_pkg::pbr_byte_t paged_rdata_i, // Paged read data
	output logic paged_wr_o, // Paged write pulse
	output logic [3:0] paged_addr_o, // Paged write address
	output logic [7:0] paged_wdata_o, // Paged write data
	output logic [2:0] page_sel_o, // Selected page
	output logic [3:0] port_sel_o, // Selected port
	input wire logic link_power_status_in_i, // Link power status
	input wire logic link_request_in_i, // Link request
	output logic llc_if_active_o, // Link interface active
	output logic link_req_accept_o, // Link request served
	input wire logic cable_power_sense_i, // Cable power sense
	input wire logic [2:0] power_class_pins_i, // Power class straps
	input wire logic arb_loop_timeout_i, // Tree-ID start timeout
	input wire logic state_timeout_i, // State timeout pulse
	input wire logic bus_reset_i, // Bus reset occurred pulse
	input wire logic bus_opportunity_i, // Arbitration slot free
	input wire pbr_pkg::pbr_ports_t port_bias_i, // Port bias
	input wire pbr_pkg::pbr_ports_t port_conn_i, // Port connected
	input wire pbr_pkg::pbr_ports_t port_dis_i, // Port disabled
	input wire pbr_pkg::pbr_ports_t port_fault_i, // Port fault
	input wire pbr_pkg::pbr_ports_t port_int_en_i, // Port irq enable
	input wire pbr_pkg::pbr_ports_t port_resume_i, // Port resuming
	output logic selfid_l_o, // Self-ID L bit 9
	output logic selfid_c_o, // Self-ID contender bit 20
	output logic [2:0] selfid_pwr_o, // Self-ID power bits 21-23
	output logic link_wake_o, // Activate link layer
	output logic short_bus_reset_o, // Short bus reset active
	output logic timeout_bus_reset_o, // Bus reset after timeout
	output logic enab_accel_o, // Accelerated arbitration
	output logic enab_multi_o // Multispeed concatenation
);
	import pbr_pkg::*;

	typedef struct packed {
		logic link_ctrl;
		logic contender;
		logic [2:0] pwr_class;
		logic pwr_load;
		logic watchdog;
		logic short_bus_reset_req;
		logic loop_f;
		logic pwr_fail;
		logic timeout;
		logic port_event;
		logic accel;
		logic multi;
		logic [2:0] page;
		logic [3:0] port;
		logic cps_q;
		pbr_cnt_t sbr_cnt;
		logic sbr_out;
		pbr_cnt_t sbr_run;
		logic tmo_rst;
		pbr_byte_t rdata;
		logic rvalid;
		logic l_bit;
		logic wake;
		logic llc_on;
		logic req_ok;
		logic paged_wr;
		logic [3:0] paged_addr;
		pbr_byte_t paged_wdata;
	} pbr_st_t;

	localparam pbr_cnt_t SBR_CNT = pbr_cnt_t'(`PBR_SBR_CYCLES);

	pbr_st_t st;
	pbr_st_t next_st;
	pbr_evt_if evif ();

	assign evif.bias = port_bias_i;
	assign evif.conn = port_conn_i;
	assign evif.dis = port_dis_i;
	assign evif.fault = port_fault_i;
	assign evif.int_en = port_int_en_i;
	assign evif.resume = port_resume_i;

	pbr_port_evt u_evt (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.ev(evif.det)
	);

	function automatic logic is_paged(input logic [3:0] a);
		is_paged = a[`PBR_ADDR_PAGED_BIT];
	endfunction : is_paged

	function automatic logic page_rsvd(input logic [2:0] p);
		page_rsvd = (p >= `PBR_PAGE_RSVD_LO) && (p <= `PBR_PAGE_RSVD_HI);
	endfunction : page_rsvd

	function automatic pbr_byte_t base_rd(input logic [3:0] a,
		input pbr_st_t s, input logic cable_power_sense);
		base_rd = 8'h00;
		case (a)
			`PBR_ADDR_STATUS: base_rd[`PBR_B0_CPS] = cable_power_sense;
			`PBR_ADDR_CAPS: base_rd = {`PBR_EXT_CODE, 1'b0,
				`PBR_PORT_COUNT};
			`PBR_ADDR_SPEED: base_rd = {`PBR_SPEED_CODE, 1'b0,
				`PBR_DELAY_CODE};
			`PBR_ADDR_NODE: base_rd = {s.link_ctrl, s.contender,
				`PBR_JITTER_CODE, s.pwr_class};
			`PBR_ADDR_EVENT: base_rd = {s.watchdog, s.short_bus_reset_req, s.loop_f,
				s.pwr_fail, s.timeout, s.port_event, s.accel, s.multi};
			`PBR_ADDR_SELECT: base_rd = {s.page, 1'b0, s.port};
			default: base_rd = 8'h00;
		endcase
	endfunction : base_rd

	logic wr_node;
	logic wr_event;
	logic wr_sel;
	logic clr_loop;
	logic clr_pfail;
	logic clr_tmo;
	logic clr_pevt;

	// Capability registers have no write decode at all
	assign wr_node = reg_wr_i && (reg_addr_i == `PBR_ADDR_NODE);
	assign wr_event = reg_wr_i && (reg_addr_i == `PBR_ADDR_EVENT);
	assign wr_sel = reg_wr_i && (reg_addr_i == `PBR_ADDR_SELECT);
	assign clr_loop = wr_event && reg_wdata_i[`PBR_B5_LOOP];
	assign clr_pfail = wr_event && reg_wdata_i[`PBR_B5_PFAIL];
	assign clr_tmo = wr_event && reg_wdata_i[`PBR_B5_TMO];
	assign clr_pevt = wr_event && reg_wdata_i[`PBR_B5_PEVT];

	always_comb begin
		next_st = st;
		next_st.cps_q = cable_power_sense_i;
		// Straps are taken the cycle after reset release
		next_st.pwr_load = 1'b0;
		if (st.pwr_load) begin
			next_st.pwr_class = power_class_pins_i;
		end
		if (wr_node) begin
			next_st.link_ctrl = reg_wdata_i[`PBR_B4_LINK_ACTIVE_CTRL];
			next_st.contender = reg_wdata_i[`PBR_B4_CONT];
			next_st.pwr_class = reg_wdata_i[2:0];
		end
		if (wr_event) begin
			next_st.watchdog = reg_wdata_i[`PBR_B5_WDOG];
			next_st.accel = reg_wdata_i[`PBR_B5_ACCEL];
			next_st.multi = reg_wdata_i[`PBR_B5_MULTI];
		end
		if (wr_sel) begin
			next_st.page = reg_wdata_i[7:5];
			next_st.port = reg_wdata_i[3:0];
		end
		// Set wins over a same-cycle write-one clear
		next_st.loop_f = (st.loop_f & ~clr_loop) | arb_loop_timeout_i;
		next_st.pwr_fail = (st.pwr_fail & ~clr_pfail) |
			(st.cps_q & ~cable_power_sense_i);
		next_st.timeout = (st.timeout & ~clr_tmo) | state_timeout_i;
		next_st.port_event = (st.port_event & ~clr_pevt) | evif.change |
			(st.watchdog & evif.resume_any);
		next_st.tmo_rst = state_timeout_i;
		// Short reset: the end of our own reset counts as a bus reset
		if (st.sbr_cnt != 6'h00) begin
			next_st.sbr_cnt = st.sbr_cnt - 6'h01;
			if (st.sbr_cnt == 6'h01) begin
				next_st.short_bus_reset_req = 1'b0;
			end
		end else if (st.short_bus_reset_req && bus_opportunity_i) begin
			next_st.sbr_cnt = SBR_CNT;
		end
		if (bus_reset_i) begin
			next_st.short_bus_reset_req = 1'b0;
		end
		// Writing zero never withdraws a pending request
		if (wr_event && reg_wdata_i[`PBR_B5_SHORT_BUS_RESET_REQ]) begin
			next_st.short_bus_reset_req = 1'b1;
		end
		next_st.sbr_out = (next_st.sbr_cnt != 6'h00);
		// Independent length witness, counts output cycles only
		next_st.sbr_run = st.sbr_out ? st.sbr_run + 6'h01 : 6'h00;
		next_st.l_bit = st.link_ctrl & link_power_status_in_i;
		next_st.llc_on = link_power_status_in_i;
		next_st.req_ok = link_power_status_in_i & link_request_in_i;
		next_st.wake = st.loop_f & st.watchdog &
			~link_power_status_in_i;
		next_st.rvalid = reg_rd_i;
		if (reg_rd_i) begin
			if (is_paged(reg_addr_i)) begin
				next_st.rdata = page_rsvd(st.page) ? 8'h00 :
					paged_rdata_i;
			end else begin
				next_st.rdata = base_rd(reg_addr_i, st,
					cable_power_sense_i);
			end
		end
		next_st.paged_wr = reg_wr_i && is_paged(reg_addr_i) &&
			!page_rsvd(st.page);
		if (reg_wr_i && is_paged(reg_addr_i)) begin
			next_st.paged_addr = reg_addr_i;
			next_st.paged_wdata = reg_wdata_i;
		end
		if (!rstn_i) begin
			next_st = '0;
			next_st.link_ctrl = `PBR_RST_LINK_ACTIVE_CTRL;
			next_st.contender = `PBR_RST_CONT;
			next_st.pwr_load = 1'b1;
			next_st.watchdog = `PBR_RST_FLAG;
			next_st.accel = `PBR_RST_FLAG;
			next_st.multi = `PBR_RST_FLAG;
			next_st.page = `PBR_RST_PAGE;
			next_st.port = `PBR_RST_PORT;
			next_st.cps_q = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st <= next_st;
	end

	assign reg_rdata_o = st.rdata;
	assign reg_rvalid_o = st.rvalid;
	assign paged_wr_o = st.paged_wr;
	assign paged_addr_o = st.paged_addr;
	assign paged_wdata_o = st.paged_wdata;
	assign page_sel_o = st.page;
	assign port_sel_o = st.port;
	assign llc_if_active_o = st.llc_on;
	assign link_req_accept_o = st.req_ok;
	assign selfid_l_o = st.l_bit;
	assign selfid_c_o = st.contender;
	assign selfid_pwr_o = st.pwr_class;
	assign link_wake_o = st.wake;
	assign short_bus_reset_o = st.sbr_out;
	assign timeout_bus_reset_o = st.tmo_rst;
	assign enab_accel_o = st.accel;
	assign enab_multi_o = st.multi;

	sequence s_rd_at(logic [3:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence

	sequence s_cps_fall;
		cable_power_sense_i ##1 !cable_power_sense_i;
	endsequence

	chk_caps_const: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) s_rd_at(`PBR_ADDR_CAPS) |=>
		reg_rvalid_o && reg_rdata_o == 8'hE2)
		else $error("caps register not E2");
	chk_speed_delay: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) s_rd_at(`PBR_ADDR_SPEED) |=>
		reg_rdata_o == 8'h40)
		else $error("speed register not 40");
	chk_jitter_zero: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) s_rd_at(`PBR_ADDR_NODE) |=>
		reg_rdata_o[5:3] == 3'h0 &&
		reg_rdata_o[2:0] == $past(selfid_pwr_o))
		else $error("jitter field not zero");
	chk_lbit_and: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) ##1 selfid_l_o ==
		($past(st.link_ctrl) && $past(link_power_status_in_i)))
		else $error("self-ID L bit wrong");
	chk_link_active_ctrl_reset: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) $rose(rstn_i) |-> st.link_ctrl &&
		!enab_accel_o && !enab_multi_o && page_sel_o == 3'h0)
		else $error("reset values wrong");
	chk_llc_follow: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) link_power_status_in_i && link_request_in_i
		|=> llc_if_active_o && link_req_accept_o)
		else $error("link request not served");
	chk_sbr_len: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) $fell(short_bus_reset_o) |->
		st.sbr_run == SBR_CNT)
		else $error("short bus reset length wrong");
	chk_sbr_bound: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) short_bus_reset_o |->
		st.sbr_run < SBR_CNT)
		else $error("short bus reset too long");
	chk_loop_set: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) arb_loop_timeout_i |=> st.loop_f)
		else $error("loop flag not set");
	chk_link_wake: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) st.loop_f && st.watchdog &&
		!link_power_status_in_i |=> link_wake_o)
		else $error("link not woken");
	chk_pfail_edge: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) s_cps_fall |=> st.pwr_fail)
		else $error("power fail not flagged");
	chk_tmo_reset: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) state_timeout_i |=>
		timeout_bus_reset_o && st.timeout)
		else $error("timeout not handled");
	chk_w1c_keep: assert property (@(posedge sys_clk_i)
		disable iff (!rstn_i) wr_event && !reg_wdata_i[`PBR_B5_PEVT] &&
		st.port_event |=> st.port_event)
		else $error("port event lost on zero write");
endmodule : pbr_base_regs

/* File: pbr_llc_model.sv */
// Purpose: Link-layer side stand-in with paged register source
// Assumes: Paged data is combinational from address, page and port
// Notes: Ports above one are unimplemented and read as zero on page 0 only
`timescale 1ns/1ps
module pbr_llc_model (
	input wire logic lps_cmd_i, // Link powered request from bench
	input wire logic req_cmd_i, // Link request from bench
	input wire logic [3:0] addr_i, // Register address
	input wire logic [2:0] page_i, // Selected page
	input wire logic [3:0] port_i, // Selected port
	output logic lps_o, // Link power status
	output logic link_request_in_o, // Link request
	output logic [7:0] paged_rdata_o // Paged read data
);
	assign lps_o = lps_cmd_i;
	// Request only makes sense while the link is powered
	assign link_request_in_o = req_cmd_i & lps_cmd_i;
	always_comb begin
		if (page_i == 3'h0 && port_i > 4'h1)
			paged_rdata_o = 8'h00;
		else
			paged_rdata_o = {1'b1, page_i, addr_i};
	end
endmodule : pbr_llc_model

/* File: tb_serial_bus_phy_base_registers.sv */
// Purpose: Self-checking bench of the PHY base register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Every register access is followed by one idle edge
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
	err_count++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb_serial_bus_phy_base_registers;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] a_i = 4'h0;
	logic wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0] wd_i = 8'h00, rdata, pg_data, paged_wdata;
	logic pw_seen;
	logic rvalid, paged_wr, link_power_status_in, link_request_in, if_act, req_acc, wake;
	logic lps_cmd = 1'b0, req_cmd = 1'b0, cable_power_sense = 1'b1, loop_to = 1'b0;
	logic st_to = 1'b0, bus_rst = 1'b0, opp = 1'b0;
	logic sid_l, sid_c, sbr, tmo_br, accel, multi;
	logic [2:0] page, pwr;
	logic [3:0] port, paged_addr;
	logic [1:0] conn = 2'h0, int_en = 2'h0, resume = 2'h0;
	logic [1:0] bias = 2'h0, dis = 2'h0, fault = 2'h0;
	int err_count = 0, n_tests = 0, cnt;
	always #20 sys_clk_i = ~sys_clk_i;
	pbr_llc_model i_llc (.lps_cmd_i(lps_cmd), .req_cmd_i(req_cmd),
		.addr_i(a_i), .page_i(page), .port_i(port), .lps_o(link_power_status_in),
		.link_request_in_o(link_request_in), .paged_rdata_o(pg_data));
	pbr_base_regs i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.reg_addr_i(a_i), .reg_wr_i(wr_i), .reg_rd_i(rd_i),
		.reg_wdata_i(wd_i), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.paged_rdata_i(pg_data), .paged_wr_o(paged_wr),
		.paged_addr_o(paged_addr), .paged_wdata_o(paged_wdata),
		.page_sel_o(page), .port_sel_o(port),
		.link_power_status_in_i(link_power_status_in), .link_request_in_i(link_request_in),
		.llc_if_active_o(if_act), .link_req_accept_o(req_acc),
		.cable_power_sense_i(cable_power_sense), .power_class_pins_i(3'h5),
		.arb_loop_timeout_i(loop_to), .state_timeout_i(st_to),
		.bus_reset_i(bus_rst), .bus_opportunity_i(opp),
		.port_bias_i(bias), .port_conn_i(conn), .port_dis_i(dis),
		.port_fault_i(fault), .port_int_en_i(int_en),
		.port_resume_i(resume), .selfid_l_o(sid_l), .selfid_c_o(sid_c),
		.selfid_pwr_o(pwr), .link_wake_o(wake),
		.short_bus_reset_o(sbr), .timeout_bus_reset_o(tmo_br),
		.enab_accel_o(accel), .enab_multi_o(multi));
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		a_i = a;
		wd_i = v;
		wr_i = 1'b1;
		cyc(1);
		wr_i = 1'b0;
		// Paged write pulse stands for this cycle only
		pw_seen = paged_wr;
		cyc(1);
	endtask : wr
	// Read data is taken in the cycle the valid pulse stands
	task automatic rd(input logic [3:0] a, input logic [7:0] ex);
		a_i = a;
		rd_i = 1'b1;
		cyc(1);
		rd_i = 1'b0;
		`CHK("rvalid", 1'b1, rvalid)
		`CHK("rdata", ex, rdata)
		// Idle edge so back-to-back calls never retoggle the strobe
		cyc(1);
	endtask : rd
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	task automatic t_caps;
		rd(4'h2, 8'hE2);
		rd(4'h3, 8'h40);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'hFF);
		rd(4'h2, 8'hE2);
		rd(4'h3, 8'h40);
		rd(4'h6, 8'h00);
		$display("done caps");
	endtask : t_caps
	task automatic t_reset;
		rd(4'h4, 8'h85);
		rd(4'h5, 8'h00);
		rd(4'h7, 8'h00);
		`CHK("pwr", 3'h5, pwr)
		$display("done reset");
	endtask : t_reset
	task automatic t_flags;
		pulse(loop_to);
		cable_power_sense = 1'b0;
		st_to = 1'b1;
		cyc(1);
		st_to = 1'b0;
		`CHK("tmo_br", 1'b1, tmo_br)
		cyc(2);
		rd(4'h0, 8'h00);
		rd(4'h5, 8'h38);
		wr(4'h5, 8'h00);
		rd(4'h5, 8'h38);
		wr(4'h5, 8'h38);
		cable_power_sense = 1'b1;
		rd(4'h5, 8'h00);
		$display("done flags");
	endtask : t_flags
	task automatic t_wake;
		wr(4'h5, 8'h80);
		pulse(loop_to);
		cyc(3);
		`CHK("wake", 1'b1, wake)
		rd(4'h5, 8'hA0);
		wr(4'h5, 8'h20);
		cyc(2);
		`CHK("wake", 1'b0, wake)
		$display("done wake");
	endtask : t_wake
	task automatic t_port;
		int_en = 2'h1;
		conn = 2'h2;
		cyc(4);
		rd(4'h5, 8'h00);
		conn = 2'h3;
		cyc(4);
		rd(4'h5, 8'h04);
		wr(4'h5, 8'h00);
		rd(4'h5, 8'h04);
		wr(4'h5, 8'h84);
		rd(4'h5, 8'h80);
		resume = 2'h1;
		cyc(4);
		rd(4'h5, 8'h84);
		wr(4'h5, 8'h04);
		dis = 2'h1;
		cyc(4);
		rd(4'h5, 8'h04);
		wr(4'h5, 8'h04);
		bias = 2'h1;
		cyc(4);
		rd(4'h5, 8'h00);
		fault = 2'h1;
		cyc(4);
		rd(4'h5, 8'h04);
		wr(4'h5, 8'h04);
		$display("done port");
	endtask : t_port
	task automatic t_sbr;
		opp = 1'b1;
		cnt = 0;
		wr(4'h5, 8'h43);
		repeat (60) begin
			if (sbr === 1'b1)
				cnt++;
			cyc(1);
		end
		`CHK("sbr_len", 33, cnt)
		rd(4'h5, 8'h03);
		`CHK("accel", 1'b1, accel)
		`CHK("multi", 1'b1, multi)
		opp = 1'b0;
		wr(4'h5, 8'h43);
		rd(4'h5, 8'h43);
		`CHK("sbr", 1'b0, sbr)
		pulse(bus_rst);
		rd(4'h5, 8'h03);
		$display("done sbr");
	endtask : t_sbr
	task automatic t_page;
		wr(4'h7, 8'h23);
		`CHK("page", 3'h1, page)
		`CHK("port", 4'h3, port)
		wr(4'h8, 8'h5A);
		`CHK("pwr_o", 1'b1, pw_seen)
		`CHK("paddr", 4'h8, paged_addr)
		`CHK("pwdata", 8'h5A, paged_wdata)
		rd(4'h8, 8'h98);
		rd(4'h2, 8'hE2);
		wr(4'h7, 8'h60);
		wr(4'h9, 8'h11);
		`CHK("pwr_o", 1'b0, pw_seen)
		rd(4'h9, 8'h00);
		pulse(bus_rst);
		rd(4'h7, 8'h60);
		$display("done page");
	endtask : t_page
	task automatic t_selfid;
		lps_cmd = 1'b1;
		req_cmd = 1'b1;
		cyc(2);
		`CHK("sid_l", 1'b1, sid_l)
		wr(4'h4, 8'h47);
		cyc(2);
		`CHK("sid_l", 1'b0, sid_l)
		`CHK("if_act", 1'b1, if_act)
		`CHK("req_acc", 1'b1, req_acc)
		`CHK("sid_c", 1'b1, sid_c)
		`CHK("pwr", 3'h7, pwr)
		pulse(bus_rst);
		rd(4'h4, 8'h47);
		$display("done selfid");
	endtask : t_selfid
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		cyc(12);
		rstn_i = 1'b1;
		cyc(1);
		t_caps;
		t_reset;
		t_flags;
		t_wake;
		t_port;
		t_sbr;
		t_page;
		t_selfid;
		print_verdict;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#(40 * 5000);
		err_count++;
		print_verdict;
	end
endmodule : tb_serial_bus_phy_base_registers
